// ### src/low_power_mode_control.sv
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps

// Notes on behaviour
// - power_mode_select 00/01/10/11 picks light sleep, deep sleep, standby, halt.
// - Each deeper mode stops CPU, then system, then PLL and watchdog, then oscillator.
// - Low power only after the sleep instruction; otherwise every clock runs.
// - Light sleep ends on reset or any unmasked interrupt, peripherals included.
// - Real-time tick interrupt ends light, deep and standby, never halt.
// - Reset, nonmaskable irq or enabled ext_irq1..3 end every mode.
// - Reset or nonmaskable wake sends the core straight to its routine.
// - Maskable wake with global_int_mask 0 runs the routine, then resumes.
// - Maskable wake with global_int_mask 1 skips the routine and resumes.
// - Sleep instruction advances the program counter once; reset restarts instead.
// - Stay in the mode until a qualifying wake event arrives, then exit.
// - Masked external irq restarts all clocks but the core keeps sleeping.
// - External pin wake requests restart clocks through a combinational path.
// - After a PLL-stopping mode, full speed waits for PLL relock.
module low_power_mode_control #(
    parameter int OSC_START_CYCLES = lpm_pkg::OSC_START_CYC,
    parameter int PLL_LOCK_CYCLES  = lpm_pkg::PLL_LOCK_CYC
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Core side
    input  wire logic                  sleep_exec,
    input  wire logic                  global_int_mask,
    input  wire logic                  reset_pin_n,
    input  wire lpm_pkg::wake_src_t    wake_src,
    output logic                       pc_advance,
    output logic                       core_sleeping,
    output logic                       wake_done,
    output logic                       run_isr,
    output lpm_pkg::wake_cause_t       wake_cause,
    // Clock module side
    output lpm_pkg::clk_en_t           clk_en,
    output logic                       wake_async_req
);
    import lpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic needs_relock(input power_mode_t m);
        needs_relock = (m == MODE_STANDBY) || (m == MODE_HALT);
    endfunction : needs_relock

    // Clock gates for a mode while asleep
    function automatic clk_en_t mode_clocks(input power_mode_t m);
        clk_en_t c;
        c      = CLK_ALL_ON;
        c.cpu  = 1'b0;
        c.sys  = (m == MODE_LIGHT_SLEEP);
        c.pll  = !needs_relock(m);
        c.wdog = !needs_relock(m);
        c.osc  = (m != MODE_HALT);
        mode_clocks = c;
    endfunction : mode_clocks

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [1:0]       pms_r;
    logic [2:0]       ext_en_r;
    power_mode_t      mode_r;
    lp_state_t        state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    wake_cause_t      cause_r, cause_nxt;
    clk_en_t          clk_en_nxt;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire acc_setup = psel && !penable;
    wire wr_take   = psel && penable && pwrite && pready;
    wire hit_ctrl  = (paddr == CLK_CTRL0_ADDR);
    wire hit_stat  = (paddr == STATUS_ADDR);
    wire [31:0] ctrl_word = {27'h000_0000, ext_en_r, pms_r};
    wire [31:0] stat_word = {25'h000_0000, cause_r, state_r, mode_r};
    wire [31:0] rd_word   = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);

    // Answer one cycle after setup: zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_setup;
            prdata  <= (acc_setup && !pwrite) ? rd_word : 32'h0000_0000;
            pslverr <= acc_setup && !hit_ctrl && !hit_stat;
        end
    end

    // Control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pms_r    <= PMS_RESET;
            ext_en_r <= EXT_EN_RESET;
        end else if (wr_take && hit_ctrl) begin
            pms_r    <= pwdata[PMS_LSB +: 2];
            ext_en_r <= pwdata[EXT_EN_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake qualification
    wire ext_unmasked = |(wake_src.ext_irq & ext_en_r);
    wire ext_masked   = |(wake_src.ext_irq & ~ext_en_r);
    wire rst_wake     = !reset_pin_n;
    wire nmi_wake     = wake_src.nonmaskable_irq;
    // Maskable sources per mode
    wire light_any    = wake_src.periph_irq || wake_src.periph_wake;
    wire rti_ok       = wake_src.rti_irq && (mode_r != MODE_HALT);
    wire mask_wake    = ext_unmasked || rti_ok || wake_src.periph_wake ||
                        (light_any && mode_r == MODE_LIGHT_SLEEP);
    wire any_wake     = rst_wake || nmi_wake || mask_wake;
    // Parked still counts as asleep for the core
    wire asleep       = (state_r == ST_SLEEP) || (state_r == ST_PARKED);
    wire relock       = needs_relock(mode_r);
    wire [CNT_W-1:0] settle_len = (mode_r == MODE_HALT)
                     ? CNT_W'(OSC_START_CYCLES + PLL_LOCK_CYCLES)
                     : CNT_W'(PLL_LOCK_CYCLES);

    // Clock restart without any running clock
    assign wake_async_req = nmi_wake || (|wake_src.ext_irq) || rst_wake;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        cause_nxt  = cause_r;
        clk_en_nxt = CLK_ALL_ON;
        case (state_r)
            ST_RUN: begin
                if (sleep_exec) begin
                    state_nxt  = ST_SLEEP;
                    clk_en_nxt = mode_clocks(power_mode_t'(pms_r));
                end
            end
            ST_SLEEP, ST_PARKED: begin
                clk_en_nxt = (state_r == ST_PARKED) ? CLK_ALL_ON : mode_clocks(mode_r);
                if (any_wake) begin
                    cause_nxt = rst_wake ? CAUSE_RESET :
                                (nmi_wake ? CAUSE_NMI : CAUSE_MASKABLE);
                    if (relock) begin
                        state_nxt  = ST_SETTLE;
                        cnt_nxt    = settle_len;
                        clk_en_nxt = mode_clocks(MODE_LIGHT_SLEEP);
                        clk_en_nxt.sys = 1'b0;
                    end else begin
                        // Clocks back on before the core resumes
                        state_nxt  = ST_WAKE;
                        clk_en_nxt = CLK_ALL_ON;
                    end
                end else if (ext_masked && state_r == ST_SLEEP) begin
                    state_nxt = ST_PARKED;
                end
            end
            ST_SETTLE: begin
                // Oscillator and PLL run while the core waits for lock
                clk_en_nxt     = mode_clocks(MODE_LIGHT_SLEEP);
                clk_en_nxt.sys = 1'b0;
                if (cnt_r <= CNT_W'(1)) begin
                    state_nxt  = ST_WAKE;
                    clk_en_nxt = CLK_ALL_ON;
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
            ST_WAKE: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RUN;
            cnt_r   <= '0;
            cause_r <= CAUSE_NONE;
            clk_en  <= CLK_ALL_ON;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cause_r <= cause_nxt;
            clk_en  <= clk_en_nxt;
        end
    end

    // Mode captured at the sleep instruction only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_LIGHT_SLEEP;
        end else if (state_r == ST_RUN && sleep_exec) begin
            mode_r <= power_mode_t'(pms_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core handshake outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_advance    <= 1'b0;
            core_sleeping <= 1'b0;
            wake_done     <= 1'b0;
            run_isr       <= 1'b0;
            wake_cause    <= CAUSE_NONE;
        end else begin
            pc_advance    <= (state_r == ST_RUN) && sleep_exec;
            core_sleeping <= (state_nxt != ST_RUN) && (state_nxt != ST_WAKE);
            wake_done     <= (state_nxt == ST_WAKE);
            // Reset and nmi always vector; maskable obeys the global mask
            run_isr       <= (state_nxt == ST_WAKE) &&
                             (cause_nxt != CAUSE_MASKABLE || !global_int_mask);
            wake_cause    <= (state_nxt == ST_WAKE) ? cause_nxt : CAUSE_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_enter;
        state_r == ST_RUN && sleep_exec;
    endsequence

    // Entry, gating and wake checks
    chk_pc_on_entry: assert property (s_enter |=> pc_advance && core_sleeping)
        else $error("sleep entry did not advance pc");
    chk_mode_latched: assert property (s_enter |=> mode_r == $past(pms_r))
        else $error("mode not captured at sleep");
    chk_mode_holds: assert property (asleep && $past(asleep) |-> $stable(mode_r))
        else $error("mode changed while asleep");
    chk_run_clocks: assert property (state_r == ST_RUN && $past(state_r) == ST_RUN
                                     |-> clk_en == CLK_ALL_ON)
        else $error("clock gated while running");
    chk_mode_gates: assert property (state_r == ST_SLEEP && $past(state_r) == ST_SLEEP
                                     |-> clk_en == mode_clocks(mode_r))
        else $error("wrong clock gates for mode");
    chk_halt_rti: assert property (state_r == ST_SLEEP && mode_r == MODE_HALT &&
                                   wake_src.rti_irq && !rst_wake && !nmi_wake &&
                                   !wake_src.periph_wake && !(|wake_src.ext_irq)
                                   |=> state_r == ST_SLEEP)
        else $error("real-time tick ended halt");
    chk_nmi_wakes: assert property (asleep && nmi_wake && !rst_wake && !relock
                                    |=> wake_done && run_isr &&
                                        wake_cause == CAUSE_NMI ##1 state_r == ST_RUN)
        else $error("nmi wake not taken to routine");
    chk_mask_isr: assert property (asleep && mask_wake && !rst_wake && !nmi_wake &&
                                   !relock |=> wake_done && run_isr == !$past(global_int_mask))
        else $error("maskable wake isr select wrong");
    chk_parked: assert property (state_r == ST_SLEEP && ext_masked && !any_wake
                                 |=> state_r == ST_PARKED ##1 clk_en == CLK_ALL_ON
                                     && (core_sleeping || wake_done))
        else $error("masked ext irq did not park");
    chk_relock_wait: assert property (state_r == ST_SETTLE && cnt_r > CNT_W'(1)
                                      |=> !clk_en.cpu && !wake_done)
        else $error("full speed before relock");
    chk_async_req: assert property (|wake_src.ext_irq |-> wake_async_req)
        else $error("pin wake not forwarded");

    // Sleep with no wake event pending and no masked pin to park on
    sequence s_quiet_sleep;
        asleep && !any_wake && !(state_r == ST_SLEEP && ext_masked);
    endsequence

    // Enabled external pin while asleep
    sequence s_ext_pin_wake;
        asleep && ext_unmasked;
    endsequence

    // Exit, wake and hold checks
    chk_resume_clocks: assert property (wake_done |->
                                        clk_en == CLK_ALL_ON && !core_sleeping)
        else $error("core resumed with clocks gated");
    chk_light_any: assert property (asleep && mode_r == MODE_LIGHT_SLEEP &&
                                    wake_src.periph_irq |=> wake_done)
        else $error("peripheral irq did not end light sleep");
    chk_ext_exit: assert property (s_ext_pin_wake |=> !asleep)
        else $error("enabled ext irq did not end sleep");
    chk_reset_exit: assert property (asleep && rst_wake |=>
                                     !asleep && cause_r == CAUSE_RESET)
        else $error("reset wake not taken");
    chk_stay_asleep: assert property (s_quiet_sleep |=> asleep)
        else $error("left sleep without a wake event");

endmodule : low_power_mode_control

// ### src/lpm_pkg.sv
package lpm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the APB
    localparam logic [7:0] CLK_CTRL0_ADDR = 8'h00;  // clock_control_reg0
    localparam logic [7:0] STATUS_ADDR    = 8'h04;  // status of the controller

    // clock_control_reg0 fields
    localparam int         PMS_LSB      = 0;        // power_mode_select [1:0]
    localparam int         EXT_EN_LSB   = 2;        // ext_irq1..3 enables [4:2]
    localparam logic [1:0] PMS_RESET    = 2'h0;
    localparam logic [2:0] EXT_EN_RESET = 3'h0;

    // Status fields
    localparam int STAT_MODE_LSB  = 0;              // latched mode [1:0]
    localparam int STAT_STATE_LSB = 2;              // state code [4:2]
    localparam int STAT_CAUSE_LSB = 5;              // last wake cause [6:5]

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_START_NS  = 1_000_000;       // oscillator power-up
    localparam int PLL_LOCK_NS   = 200_000;         // PLL relock
    localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_LOCK_CYC  = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 20;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        MODE_LIGHT_SLEEP,
        MODE_DEEP_SLEEP,
        MODE_STANDBY,
        MODE_HALT
    } power_mode_t;

    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_RESET,
        CAUSE_NMI,
        CAUSE_MASKABLE
    } wake_cause_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_SLEEP,
        ST_PARKED,
        ST_SETTLE,
        ST_WAKE
    } lp_state_t;

    // Wake sources seen by the controller
    typedef struct packed {
        logic       nonmaskable_irq;
        logic [2:0] ext_irq;         // ext_irq3..ext_irq1
        logic       rti_irq;         // watchdog_tick_module real-time irq
        logic       periph_irq;      // unmasked peripheral irq, clocked
        logic       periph_wake;     // peripheral wakeup irq, clock free
    } wake_src_t;

    // Clock gates towards the clock module
    typedef struct packed {
        logic cpu;
        logic sys;
        logic pll;
        logic wdog;
        logic osc;
    } clk_en_t;

    localparam clk_en_t CLK_ALL_ON = 5'h1F;

endpackage : lpm_pkg

// ### verif/core_model.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////
// Core stand-in: issues the sleep pulse, tracks pc and routines
module core_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // From the controller
    input  wire logic pc_advance,
    input  wire logic wake_done,
    input  wire logic run_isr,
    // To the controller, and counters for the testbench
    output logic      sleep_exec,
    output int        pc_cnt,
    output int        isr_cnt
);
    // One-cycle sleep instruction, launched after an edge
    task automatic exec_sleep();
        @(posedge pclk) sleep_exec <= 1'b1;
        @(posedge pclk) sleep_exec <= 1'b0;
    endtask : exec_sleep

    // Program counter steps and service routine entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_cnt  <= 0;
            isr_cnt <= 0;
        end else begin
            pc_cnt  <= pc_cnt + int'(pc_advance);
            isr_cnt <= isr_cnt + int'(wake_done && run_isr);
        end
    end

    initial sleep_exec = 1'b0;
endmodule : core_model

// ### verif/testbench.sv
`timescale 1ns/100ps

module testbench;
    import lpm_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sleep_exec, global_int_mask, reset_pin_n, pc_advance;
    logic        core_sleeping, wake_done, run_isr, wake_async_req;
    wake_src_t   ws;
    wake_cause_t wake_cause;
    clk_en_t     clk_en;
    int          pc_cnt, isr_cnt, pc0;
    int          n_mismatch = 0;
    int          cmp_count  = 0;

    low_power_mode_control #(.OSC_START_CYCLES(4), .PLL_LOCK_CYCLES(3)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
        .global_int_mask(global_int_mask), .reset_pin_n(reset_pin_n),
        .wake_src(ws), .pc_advance(pc_advance), .core_sleeping(core_sleeping),
        .wake_done(wake_done), .run_isr(run_isr), .wake_cause(wake_cause),
        .clk_en(clk_en), .wake_async_req(wake_async_req));

    core_model core_u (
        .pclk(pclk), .presetn(presetn), .pc_advance(pc_advance),
        .wake_done(wake_done), .run_isr(run_isr), .sleep_exec(sleep_exec),
        .pc_cnt(pc_cnt), .isr_cnt(isr_cnt));

    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic clk_en_t gates(input logic [1:0] m);
        gates = {1'b0, m == 2'h0, m < 2'h2, m < 2'h2, m != 2'h3};
    endfunction : gates

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(n < 20, "apb timeout");
    endtask : apb

    task automatic drive(input wake_src_t v);
        @(posedge pclk) ws <= v;
    endtask : drive

    // Wait for the resume pulse and judge it, then release sources
    task automatic wait_wake(input wake_cause_t c, input logic isr, output int n);
        int i0;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (wake_done !== 1'b1 && n < 40);
        chk(wake_done === 1'b1, "no wake");
        chk(wake_cause === c, "wake cause");
        chk(run_isr === isr, "routine choice");
        chk(clk_en === CLK_ALL_ON && core_sleeping === 1'b0, "resume");
        i0 = isr_cnt;
        @(posedge pclk);
        ws          <= '0;
        reset_pin_n <= 1'b1;
        #1;
        chk(isr_cnt === i0 + int'(isr), "routine count");
    endtask : wait_wake

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        apb(1'b0, CLK_CTRL0_ADDR, 32'h0000_0000);
        chk(rd === 32'h0000_0000 && err === 1'b0, "ctrl reset");
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rd === 32'h0000_0000 && err === 1'b1, "unmapped");
        apb(1'b1, CLK_CTRL0_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, CLK_CTRL0_ADDR, 32'h0000_0000);
        chk(rd === 32'h0000_001F, "ctrl fields");
    endtask : t_regs

    // Each mode, its own wake source, global_int_mask set to bit 0 of the mode
    task automatic t_modes();
        wake_src_t v;
        int n;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, CLK_CTRL0_ADDR, {27'h000_0000, 3'h7, m[1:0]});
            chk(clk_en === CLK_ALL_ON, "clocks before sleep");
            global_int_mask <= m[0];
            pc0 = pc_cnt;
            core_u.exec_sleep();
            #1;
            chk(pc_advance === 1'b1 && core_sleeping === 1'b1, "entry");
            chk(clk_en === gates(m[1:0]), "mode gates");
            v = '0;
            case (m)
                0: v.periph_irq = 1'b1;
                1: v.rti_irq = 1'b1;
                2: v.periph_wake = 1'b1;
                default: v.ext_irq = 3'h4;
            endcase
            drive(v);
            #1;
            chk(wake_async_req === (m == 3), "async request");
            wait_wake(CAUSE_MASKABLE, !m[0], n);
            chk(n > (m == 2 ? 3 : m == 3 ? 7 : 0), "relock wait");
            chk(pc_cnt === pc0 + 1, "pc step");
        end
    endtask : t_modes

    task automatic t_halt();
        wake_src_t v;
        int n;
        core_u.exec_sleep();
        v = '0;
        v.rti_irq = 1'b1;
        drive(v);
        repeat (12) @(posedge pclk);
        #1;
        chk(core_sleeping === 1'b1 && clk_en === gates(2'h3), "halt kept");
        v.nonmaskable_irq = 1'b1;
        drive(v);
        wait_wake(CAUSE_NMI, 1'b1, n);
        apb(1'b1, CLK_CTRL0_ADDR, 32'h0000_001D);
        core_u.exec_sleep();
        v = '0;
        v.nonmaskable_irq = 1'b1;
        drive(v);
        wait_wake(CAUSE_NMI, 1'b1, n);
        chk(n === 1, "nmi wake latency");
    endtask : t_halt

    task automatic t_parked();
        wake_src_t v;
        int n;
        apb(1'b1, CLK_CTRL0_ADDR, 32'h0000_0000);
        core_u.exec_sleep();
        apb(1'b1, CLK_CTRL0_ADDR, 32'h0000_0003);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        chk(rd[1:0] === 2'h0 && clk_en === gates(2'h0), "mode held");
        chk(rd[4:2] === 3'h1 && rd[6:5] === 2'h2, "status fields");
        v = '0;
        v.ext_irq = 3'h1;
        drive(v);
        repeat (4) @(posedge pclk);
        #1;
        chk(clk_en === CLK_ALL_ON && core_sleeping === 1'b1, "parked");
        @(posedge pclk) reset_pin_n <= 1'b0;
        wait_wake(CAUSE_RESET, 1'b1, n);
    endtask : t_parked

    ////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #100_000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        presetn         = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 8'h00;
        pwdata          = 32'h0000_0000;
        global_int_mask = 1'b0;
        reset_pin_n     = 1'b1;
        ws              = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_halt();
        t_parked();
        wrap_up();
    end
endmodule : testbench
